// File: design/fan_drive_rate_and_ramp_control.sv
// Fan drive rate, ramp limiting, floor behaviour and register file over AXI4-Lite
// How it works
// - In low-frequency mode the 3-bit rate field picks 11.0, 14.7, 22.1, 29.4, 35.3, 44.1, 58.8 or 88.2 Hz.
// - Bit 3 of each rate register selects high-frequency drive when one, low-frequency when zero.
// - Once the lock bit is set the three rate registers ignore writes.
// - With Remote 1 ramping on and slow mode off, duty moves by 1,2,3,4,8,12,24 or 48 per slot.
// - With slow mode on the same steps use a longer slot, giving 52.2 s down to 1.1 s sweeps.
// - Bit 3 of the ramp register enables ramp limiting of Remote 1 driven changes.
// - Bit 4 of the ramp register ties speed sensing on inputs 2 to 4 to drive output 3.
// - Below the floor in automatic mode, bit 5 picks 0 % or minimum duty for output 1.
// - Below the floor in automatic mode, bit 6 picks 0 % or minimum duty for output 2.
// - Below the floor in automatic mode, bit 7 picks 0 % or minimum duty for output 3.
// - Bit 4 of each drive configuration register inverts the output polarity.
module fan_drive_rate_and_ramp_control #(
	parameter int SLOT_FAST = fan_pkg::SLOT_FAST_CYCLES,
	parameter int SLOT_SLOW = fan_pkg::SLOT_SLOW_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [7:0] AUTO_DUTY_1,
	input wire logic [7:0] AUTO_DUTY_2,
	input wire logic [7:0] AUTO_DUTY_3,
	input wire logic [2:0] BELOW_TEMP_FLOOR,
	input wire logic [2:0] REMOTE1_CONTROLS,
	output logic FAN_DRIVE_1,
	output logic FAN_DRIVE_2,
	output logic FAN_DRIVE_3,
	output logic SPEED_SENSE_2_GATE,
	output logic SPEED_SENSE_3_GATE,
	output logic SPEED_SENSE_4_GATE
);

	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// Register storage, indexed by channel
	logic [7:0] rate_q [3];
	logic [7:0] rate_d [3];
	logic [7:0] drv_q [3];
	logic [7:0] drv_d [3];
	logic [7:0] min_q [3];
	logic [7:0] min_d [3];
	logic [7:0] man_q [3];
	logic [7:0] man_d [3];
	logic [7:0] ramp_q, ramp_d, ctrl_q, ctrl_d;

	// Bus state
	logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [7:0] awidx_q, awidx_d;
	logic [7:0] wdata_q, wdata_d;
	logic wlane_q, wlane_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] cur_q [3];

	function automatic logic idx_known(input logic [7:0] idx);
		return idx inside {fan_pkg::IDX_MANUAL_DUTY_1, fan_pkg::IDX_MANUAL_DUTY_2,
			fan_pkg::IDX_MANUAL_DUTY_3, fan_pkg::IDX_CURRENT_DUTY_1,
			fan_pkg::IDX_CURRENT_DUTY_2, fan_pkg::IDX_CURRENT_DUTY_3,
			fan_pkg::IDX_DRIVE_CFG_1, fan_pkg::IDX_DRIVE_CFG_2, fan_pkg::IDX_DRIVE_CFG_3,
			fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, fan_pkg::IDX_LOCAL_SPAN_AND_DRIVE2_RATE,
			fan_pkg::IDX_REMOTE2_SPAN_AND_DRIVE3_RATE, fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR,
			fan_pkg::IDX_MIN_DUTY_1, fan_pkg::IDX_MIN_DUTY_2, fan_pkg::IDX_MIN_DUTY_3,
			fan_pkg::IDX_CONTROL};
	endfunction

	assign S_AXI_AWREADY = !aw_q && !bvalid_q;
	assign S_AXI_WREADY = !w_q && !bvalid_q;
	assign S_AXI_ARREADY = !rvalid_q;

	logic do_write, locked;
	assign do_write = aw_q && w_q && wlane_q;
	assign locked = ctrl_q[fan_pkg::LOCK_BIT];

	always_comb
	begin
		aw_d = aw_q;
		awidx_d = awidx_q;
		w_d = w_q;
		wdata_d = wdata_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			aw_d = 1'b1;
			awidx_d = S_AXI_AWADDR[9:2];
		end
		if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			w_d = 1'b1;
			wdata_d = S_AXI_WDATA[7:0];
			wlane_d = S_AXI_WSTRB[0];
		end
		if (aw_q && w_q)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = idx_known(awidx_q) ? fan_pkg::RESP_OKAY : fan_pkg::RESP_SLVERR;
		end
		else if (bvalid_q && S_AXI_BREADY)
			bvalid_d = 1'b0;
	end

	always_comb
	begin
		rate_d = rate_q;
		drv_d = drv_q;
		min_d = min_q;
		man_d = man_q;
		ramp_d = ramp_q;
		ctrl_d = ctrl_q;
		if (do_write)
		begin
			for (int i = 0; i < 3; i++)
			begin
				// Span bits in [7:4] are stored as written and not decoded here
				if (awidx_q == fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE + 8'(i) && !locked)
					rate_d[i] = wdata_q;
				if (awidx_q == fan_pkg::IDX_DRIVE_CFG_1 + 8'(i))
					drv_d[i] = wdata_q;
				if (awidx_q == fan_pkg::IDX_MIN_DUTY_1 + 8'(i))
					min_d[i] = wdata_q;
				if (awidx_q == fan_pkg::IDX_MANUAL_DUTY_1 + 8'(i))
					man_d[i] = wdata_q;
			end
			if (awidx_q == fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR && !locked)
				ramp_d = wdata_q;
			// Lock can be set but only reset clears it
			if (awidx_q == fan_pkg::IDX_CONTROL)
				ctrl_d = wdata_q | {7'h00, locked};
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_q <= 1'b0;
			awidx_q <= 8'h00;
			w_q <= 1'b0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= fan_pkg::RESP_OKAY;
			for (int i = 0; i < 3; i++)
			begin
				rate_q[i] <= fan_pkg::RATE_RESET;
				drv_q[i] <= fan_pkg::DRIVE_CFG_RESET;
				min_q[i] <= fan_pkg::MIN_DUTY_RESET;
				man_q[i] <= fan_pkg::MANUAL_DUTY_RESET;
			end
			ramp_q <= fan_pkg::RAMP_RESET;
			ctrl_q <= fan_pkg::CONTROL_RESET;
		end
		else
		begin
			aw_q <= aw_d;
			awidx_q <= awidx_d;
			w_q <= w_d;
			wdata_q <= wdata_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rate_q <= rate_d;
			drv_q <= drv_d;
			min_q <= min_d;
			man_q <= man_d;
			ramp_q <= ramp_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;

	// Read path: one cycle from address accept to data
	always_comb
	begin
		logic [7:0] v;
		logic [7:0] idx;
		v = 8'h00;
		idx = S_AXI_ARADDR[9:2];
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		for (int i = 0; i < 3; i++)
		begin
			if (idx == fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE + 8'(i))
				v = rate_q[i];
			if (idx == fan_pkg::IDX_DRIVE_CFG_1 + 8'(i))
				v = drv_q[i];
			if (idx == fan_pkg::IDX_MIN_DUTY_1 + 8'(i))
				v = min_q[i];
			if (idx == fan_pkg::IDX_MANUAL_DUTY_1 + 8'(i))
				v = man_q[i];
			if (idx == fan_pkg::IDX_CURRENT_DUTY_1 + 8'(i))
				v = cur_q[i];
		end
		if (idx == fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR)
			v = ramp_q;
		if (idx == fan_pkg::IDX_CONTROL)
			v = ctrl_q;
		if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			rvalid_d = 1'b1;
			rdata_d = {24'h000000, v};
			rresp_d = idx_known(idx) ? fan_pkg::RESP_OKAY : fan_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && S_AXI_RREADY)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= fan_pkg::RESP_OKAY;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// Duty targets, floor behaviour and ramp limiting
	logic [23:0] slot_q, slot_d;
	logic slot_tick;
	logic [7:0] cur_d [3];
	logic [7:0] auto_duty [3];
	assign auto_duty[0] = AUTO_DUTY_1;
	assign auto_duty[1] = AUTO_DUTY_2;
	assign auto_duty[2] = AUTO_DUTY_3;

	always_comb
	begin
		logic [23:0] slot_len;
		logic [7:0] step, tgt;
		logic auto_mode, limit;
		slot_len = ctrl_q[fan_pkg::SLOW_RAMP_BIT] ? 24'(SLOT_SLOW) : 24'(SLOT_FAST);
		step = fan_pkg::ramp_step(ramp_q[fan_pkg::RAMP_STEP_LSB +: 3]);
		slot_tick = (slot_q >= slot_len - 24'h000001);
		slot_d = slot_tick ? 24'h000000 : slot_q + 24'h000001;
		tgt = 8'h00;
		auto_mode = 1'b0;
		limit = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			auto_mode = ctrl_q[fan_pkg::AUTO_MODE_LSB + i];
			if (!auto_mode)
				tgt = man_q[i];
			else if (BELOW_TEMP_FLOOR[i])
				tgt = ramp_q[fan_pkg::FLOOR_HOLD_OUT1_BIT + i] ? min_q[i] : 8'h00;
			else
				tgt = auto_duty[i];
			limit = auto_mode && REMOTE1_CONTROLS[i]
				&& ramp_q[fan_pkg::REMOTE_ONE_RAMP_ENABLE_BIT];
			cur_d[i] = cur_q[i];
			if (!limit)
				cur_d[i] = tgt;
			else if (slot_tick && tgt > cur_q[i])
				cur_d[i] = (tgt - cur_q[i] > step) ? cur_q[i] + step : tgt;
			else if (slot_tick && tgt < cur_q[i])
				cur_d[i] = (cur_q[i] - tgt > step) ? cur_q[i] - step : tgt;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot_q <= 24'h000000;
			for (int i = 0; i < 3; i++)
				cur_q[i] <= 8'h00;
		end
		else
		begin
			slot_q <= slot_d;
			cur_q <= cur_d;
		end
	end

	// Drive outputs
	logic [2:0] drive, on_phase;
	fan_pkg::drive_cfg_t cfg [3];

	for (genvar g = 0; g < 3; g++)
	begin : g_ch
		assign cfg[g].fast = rate_q[g][fan_pkg::FAST_BIT];
		assign cfg[g].rate = rate_q[g][fan_pkg::RATE_LSB +: 3];
		assign cfg[g].flip = drv_q[g][fan_pkg::POLARITY_FLIP_BIT];
		fan_drive_channel u_ch (
			.clk(REF_CLK),
			.rst_n(rst_n),
			.cfg(cfg[g]),
			.duty(cur_q[g]),
			.drive(drive[g]),
			.on_phase(on_phase[g])
		);
	end

	assign FAN_DRIVE_1 = drive[0];
	assign FAN_DRIVE_2 = drive[1];
	assign FAN_DRIVE_3 = drive[2];

	// Sensing is gated to the on phase of output 3 when several fans share it
	logic gate_q, gate_d;
	always_comb
	begin
		gate_d = ramp_q[fan_pkg::SYNC_SENSE_BIT] ? on_phase[2] : 1'b1;
	end

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
			gate_q <= 1'b1;
		else
			gate_q <= gate_d;
	end

	assign SPEED_SENSE_2_GATE = gate_q;
	assign SPEED_SENSE_3_GATE = gate_q;
	assign SPEED_SENSE_4_GATE = gate_q;

endmodule

// File: include/fan_pkg.sv
// Shared constants, types and helpers for the fan drive rate and ramp block
package fan_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_MANUAL_DUTY_1 = 8'h30;
	localparam logic [7:0] IDX_MANUAL_DUTY_2 = 8'h31;
	localparam logic [7:0] IDX_MANUAL_DUTY_3 = 8'h32;
	localparam logic [7:0] IDX_CURRENT_DUTY_1 = 8'h25;
	localparam logic [7:0] IDX_CURRENT_DUTY_2 = 8'h26;
	localparam logic [7:0] IDX_CURRENT_DUTY_3 = 8'h27;
	localparam logic [7:0] IDX_DRIVE_CFG_1 = 8'h5C;
	localparam logic [7:0] IDX_DRIVE_CFG_2 = 8'h5D;
	localparam logic [7:0] IDX_DRIVE_CFG_3 = 8'h5E;
	localparam logic [7:0] IDX_REMOTE1_SPAN_AND_DRIVE1_RATE = 8'h5F;
	localparam logic [7:0] IDX_LOCAL_SPAN_AND_DRIVE2_RATE = 8'h60;
	localparam logic [7:0] IDX_REMOTE2_SPAN_AND_DRIVE3_RATE = 8'h61;
	localparam logic [7:0] IDX_RAMP_AND_FLOOR_BEHAVIOUR = 8'h62;
	localparam logic [7:0] IDX_MIN_DUTY_1 = 8'h64;
	localparam logic [7:0] IDX_MIN_DUTY_2 = 8'h65;
	localparam logic [7:0] IDX_MIN_DUTY_3 = 8'h66;
	localparam logic [7:0] IDX_CONTROL = 8'h40;

	// Reset values
	localparam logic [7:0] RATE_RESET = 8'hC4;
	localparam logic [7:0] RAMP_RESET = 8'h00;
	localparam logic [7:0] DRIVE_CFG_RESET = 8'h00;
	localparam logic [7:0] MIN_DUTY_RESET = 8'h00;
	localparam logic [7:0] MANUAL_DUTY_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Field positions
	localparam int RATE_LSB = 0;
	localparam int FAST_BIT = 3;
	localparam int SPAN_LSB = 4;
	localparam int RAMP_STEP_LSB = 0;
	localparam int REMOTE_ONE_RAMP_ENABLE_BIT = 3;
	localparam int SYNC_SENSE_BIT = 4;
	localparam int FLOOR_HOLD_OUT1_BIT = 5;
	localparam int POLARITY_FLIP_BIT = 4;
	localparam int LOCK_BIT = 0;
	localparam int SLOW_RAMP_BIT = 1;
	localparam int AUTO_MODE_LSB = 2;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing: clock 10 MHz, ramp slot from the full 0-to-100 % sweep at one step per slot
	localparam int CLOCK_HZ = 10000000;
	localparam int DUTY_FULL_STEPS = 255;
	localparam int SWEEP_FAST_MS = 37500;
	localparam int SWEEP_SLOW_MS = 52200;
	localparam int SLOT_FAST_CYCLES = SWEEP_FAST_MS * (CLOCK_HZ / 1000) / DUTY_FULL_STEPS;
	localparam int SLOT_SLOW_CYCLES = SWEEP_SLOW_MS * (CLOCK_HZ / 1000) / DUTY_FULL_STEPS;
	localparam int DUTY_LEVELS = 256;
	localparam logic [15:0] FAST_TICK_CYCLES = 16'h0002;

	typedef struct packed {
		logic fast;
		logic [2:0] rate;
		logic flip;
	} drive_cfg_t;

	// Cycles per duty tick (period / 256) for a low-frequency rate code
	function automatic logic [15:0] low_tick_cycles(input logic [2:0] code);
		int deci_hz;
		deci_hz = 353;
		unique case (code)
			3'h0: deci_hz = 110;
			3'h1: deci_hz = 147;
			3'h2: deci_hz = 221;
			3'h3: deci_hz = 294;
			3'h4: deci_hz = 353;
			3'h5: deci_hz = 441;
			3'h6: deci_hz = 588;
			3'h7: deci_hz = 882;
		endcase
		return 16'((CLOCK_HZ * 10) / (deci_hz * DUTY_LEVELS));
	endfunction

	// Duty steps allowed per ramp slot
	function automatic logic [7:0] ramp_step(input logic [2:0] code);
		logic [7:0] s;
		s = 8'h01;
		unique case (code)
			3'h0: s = 8'h01;
			3'h1: s = 8'h02;
			3'h2: s = 8'h03;
			3'h3: s = 8'h04;
			3'h4: s = 8'h08;
			3'h5: s = 8'h0C;
			3'h6: s = 8'h18;
			3'h7: s = 8'h30;
		endcase
		return s;
	endfunction

endpackage

// File: design/fan_drive_channel.sv
// One fan drive pulse output: rate divider, duty comparator and polarity
module fan_drive_channel (
	input wire logic clk,
	input wire logic rst_n,
	input fan_pkg::drive_cfg_t cfg,
	input wire logic [7:0] duty,
	output logic drive,
	output logic on_phase
);

	logic [15:0] div_q, div_d, tick_len;
	logic [7:0] cnt_q, cnt_d;
	logic drive_q, drive_d, on_q, on_d;

	always_comb
	begin
		// High-frequency mode ignores the rate field
		tick_len = cfg.fast ? fan_pkg::FAST_TICK_CYCLES : fan_pkg::low_tick_cycles(cfg.rate);
		div_d = div_q + 16'h0001;
		cnt_d = cnt_q;
		// >= keeps the divider safe when software shortens the period mid-count
		if (div_q >= tick_len - 16'h0001)
		begin
			div_d = 16'h0000;
			cnt_d = cnt_q + 8'h01;
		end
		// Full scale must be a constant level, not 255/256
		on_d = (duty == 8'hFF) || (cnt_q < duty);
		drive_d = on_d ^ cfg.flip;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= 16'h0000;
			cnt_q <= 8'h00;
			drive_q <= 1'b0;
			on_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			cnt_q <= cnt_d;
			drive_q <= drive_d;
			on_q <= on_d;
		end
	end

	assign drive = drive_q;
	assign on_phase = on_q;

endmodule

// File: dv/fan_model.sv
// Behavioural fans on the drive outputs: pulse count, last pulse width, gated cycles
module fan_model (
	input wire logic clk,
	input wire logic [2:0] drive,
	input wire logic [2:0] gate,
	output int rises,
	output int width,
	output int gated
);
	timeunit 1ns;
	timeprecision 1ns;
	int run = 0;
	logic last = 1'b0;
	initial
	begin
		rises = 0;
		width = 0;
		gated = 0;
	end
	// A fan only sees its own drive line; fan 1 is timed, sense 4 gating is counted
	always @(posedge clk)
	begin
		last <= drive[0];
		run <= drive[0] ? run + 1 : 0;
		if (drive[0] && !last)
			rises <= rises + 1;
		if (!drive[0] && last)
			width <= run;
		if (!gate[2])
			gated <= gated + 1;
	end
endmodule

// File: dv/fan_drive_asserts.sv
// Port checker for the fan drive block
module fan_drive_asserts (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic SPEED_SENSE_2_GATE,
	input wire logic SPEED_SENSE_3_GATE,
	input wire logic SPEED_SENSE_4_GATE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);
	property p_wr_answer;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_b_hold;
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_clear;
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
	endproperty
	a_b_clear: assert property (p_b_clear) else $error("write answer repeated");
	property p_aw_block;
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
	property p_rd_answer;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_r_hold;
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_ar_block;
		S_AXI_ARREADY != S_AXI_RVALID;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read ready wrong");
	property p_rd_upper;
		S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_gate_same;
		SPEED_SENSE_2_GATE == SPEED_SENSE_3_GATE && SPEED_SENSE_3_GATE == SPEED_SENSE_4_GATE;
	endproperty
	a_gate_same: assert property (p_gate_same) else $error("sense gates differ");
	c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
	c_gate: cover property ($fell(SPEED_SENSE_4_GATE));
endmodule
bind fan_drive_rate_and_ramp_control fan_drive_asserts fan_drive_asserts_i (
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.SPEED_SENSE_2_GATE(SPEED_SENSE_2_GATE), .SPEED_SENSE_3_GATE(SPEED_SENSE_3_GATE),
	.SPEED_SENSE_4_GATE(SPEED_SENSE_4_GATE));

// File: dv/testbench.sv
// Self-checking bench for the fan drive rate and ramp block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] duty1 = 8'h00;
	logic [7:0] duty2 = 8'h00;
	logic [7:0] duty3 = 8'h00;
	logic [2:0] below = 3'h0;
	logic [2:0] remote1 = 3'h0;
	logic [2:0] drive, gate;
	int rises, width, gated;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	always #50 clk = ~clk;
	fan_drive_rate_and_ramp_control #(.SLOT_FAST(10), .SLOT_SLOW(14)) fan_drive_rate_and_ramp_control_i (
		.REF_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.AUTO_DUTY_1(duty1), .AUTO_DUTY_2(duty2), .AUTO_DUTY_3(duty3),
		.BELOW_TEMP_FLOOR(below), .REMOTE1_CONTROLS(remote1),
		.FAN_DRIVE_1(drive[0]), .FAN_DRIVE_2(drive[1]), .FAN_DRIVE_3(drive[2]),
		.SPEED_SENSE_2_GATE(gate[0]), .SPEED_SENSE_3_GATE(gate[1]), .SPEED_SENSE_4_GATE(gate[2]));
	fan_model fan_model_i (.clk(clk), .drive(drive), .gate(gate), .rises(rises), .width(width),
		.gated(gated));
	task automatic final_report();
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %0d want %0d..%0d", $time, got, lo, hi);
		end
	endtask
	// Address and data are offered together and each is dropped once taken
	task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		logic [1:0] rs;
		awaddr <= {2'h0, i, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Only the bench timeout ends a wait for the answer
		forever
		begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rs = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb)
			begin
				r = rs;
				bready <= 1'b0;
				break;
			end
		end
		// Let an edge pass so a following call does not raise bready in the same step
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] r);
		logic ta, tr;
		logic [7:0] ds;
		logic [1:0] rs;
		araddr <= {2'h0, i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			ds = rdata[7:0];
			rs = rresp;
			@(posedge clk);
			if (ta)
				arvalid <= 1'b0;
			if (tr)
			begin
				d = ds;
				r = rs;
				rready <= 1'b0;
				break;
			end
		end
		@(posedge clk);
	endtask
	task automatic wc(input logic [7:0] i, input logic [7:0] d);
		logic [1:0] r;
		wr(i, d, r);
		chk({6'h00, r}, {6'h00, fan_pkg::RESP_OKAY});
	endtask
	task automatic rc(input logic [7:0] i, input logic [7:0] exp);
		logic [7:0] d;
		logic [1:0] r;
		rd(i, d, r);
		chk(d, exp);
		chk({6'h00, r}, {6'h00, fan_pkg::RESP_OKAY});
	endtask
	task automatic t_regs();
		logic [7:0] d;
		logic [1:0] r;
		for (int k = 0; k < 3; k++)
			rc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE + 8'(k), 8'hC4);
		rc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h00);
		rd(8'h00, d, r);
		chk({6'h00, r}, {6'h00, fan_pkg::RESP_SLVERR});
		wr(8'h01, 8'h5A, r);
		chk({6'h00, r}, {6'h00, fan_pkg::RESP_SLVERR});
		wc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, 8'hA4);
		rc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, 8'hA4);
		// Fast drive everywhere keeps pulse periods short enough to watch
		for (int k = 0; k < 3; k++)
			wc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE + 8'(k), 8'hC8);
		wc(fan_pkg::IDX_CONTROL, 8'h1C);
	endtask
	task automatic t_rate();
		int a;
		duty1 <= 8'h80;
		repeat (1200) @(posedge clk);
		chk_in(width, 256, 256);
		a = rises;
		repeat (2048) @(posedge clk);
		chk_in(rises - a, 3, 5);
		wc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, 8'hC7);
		a = rises;
		repeat (2048) @(posedge clk);
		chk_in(rises - a, 0, 1);
		wc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, 8'hC8);
	endtask
	task automatic t_polarity();
		duty1 <= 8'hFF;
		repeat (600) @(posedge clk);
		chk({7'h00, drive[0]}, 8'h01);
		wc(fan_pkg::IDX_DRIVE_CFG_1, 8'h10);
		repeat (600) @(posedge clk);
		chk({7'h00, drive[0]}, 8'h00);
		wc(fan_pkg::IDX_DRIVE_CFG_1, 8'h00);
	endtask
	task automatic t_floor();
		logic [7:0] pat [4] = '{8'hE0, 8'h00, 8'hA0, 8'h40};
		duty1 <= 8'h80;
		duty2 <= 8'h80;
		duty3 <= 8'h80;
		below <= 3'h7;
		for (int k = 0; k < 3; k++)
			wc(fan_pkg::IDX_MIN_DUTY_1 + 8'(k), 8'hFF);
		foreach (pat[p])
		begin
			wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, pat[p]);
			repeat (600) @(posedge clk);
			chk({7'h00, drive[0]}, {7'h00, pat[p][5]});
			chk({7'h00, drive[1]}, {7'h00, pat[p][6]});
			chk({7'h00, drive[2]}, {7'h00, pat[p][7]});
		end
		below <= 3'h0;
	endtask
	task automatic t_ramp();
		int st [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
		logic [7:0] d;
		logic [1:0] r;
		remote1 <= 3'h1;
		for (int s = 0; s < 2; s++)
		begin
			wc(fan_pkg::IDX_CONTROL, s ? 8'h1E : 8'h1C);
			for (int c = 0; c < 8; c++)
			begin
				wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h00);
				duty1 <= 8'h00;
				repeat (5) @(posedge clk);
				wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h08 | 8'(c));
				duty1 <= 8'hFF;
				repeat (s ? 70 : 50) @(posedge clk);
				rd(fan_pkg::IDX_CURRENT_DUTY_1, d, r);
				chk_in({24'h000000, d}, 4 * st[c], (6 * st[c] > 255) ? 255 : 6 * st[c]);
			end
		end
		wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h00);
		duty1 <= 8'h00;
		repeat (5) @(posedge clk);
		duty1 <= 8'hFF;
		repeat (3) @(posedge clk);
		rc(fan_pkg::IDX_CURRENT_DUTY_1, 8'hFF);
		remote1 <= 3'h0;
	endtask
	task automatic t_sync();
		int a;
		duty3 <= 8'h80;
		wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h10);
		a = gated;
		repeat (1200) @(posedge clk);
		chk_in(gated - a, 400, 800);
		wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h00);
		repeat (2) @(posedge clk);
		a = gated;
		repeat (1200) @(posedge clk);
		chk_in(gated - a, 0, 0);
	endtask
	task automatic t_lock();
		wc(fan_pkg::IDX_CONTROL, 8'h1D);
		wc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, 8'h00);
		rc(fan_pkg::IDX_REMOTE1_SPAN_AND_DRIVE1_RATE, 8'hC8);
		wc(fan_pkg::IDX_REMOTE2_SPAN_AND_DRIVE3_RATE, 8'h01);
		rc(fan_pkg::IDX_REMOTE2_SPAN_AND_DRIVE3_RATE, 8'hC8);
		wc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'hFF);
		rc(fan_pkg::IDX_RAMP_AND_FLOOR_BEHAVIOUR, 8'h00);
		// Manual mode on output 1 takes its duty from the manual register
		wc(fan_pkg::IDX_MANUAL_DUTY_1, 8'h5A);
		wc(fan_pkg::IDX_CONTROL, 8'h19);
		rc(fan_pkg::IDX_CURRENT_DUTY_1, 8'h5A);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			mismatches++;
			final_report();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_rate();
		t_polarity();
		t_floor();
		t_ramp();
		t_sync();
		t_lock();
		final_report();
	end
endmodule
